/* dtc_regs.svh */
// Register addresses, field positions and timing counts of the dual timer/counter
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// Register select codes on the special function register port
`define DTC_SEL_CONTROL 3'h0
`define DTC_SEL_MODE    3'h1
`define DTC_SEL_TMR0_LOW  3'h2
`define DTC_SEL_TMR0_HIGH 3'h3
`define DTC_SEL_TMR1_LOW  3'h4
`define DTC_SEL_TMR1_HIGH 3'h5

// Control register fields
`define DTC_CTL_OVF1  7
`define DTC_CTL_RUN1  6
`define DTC_CTL_OVF0  5
`define DTC_CTL_RUN0  4
`define DTC_CTL_EDGE1 3
`define DTC_CTL_TYPE1 2
`define DTC_CTL_EDGE0 1
`define DTC_CTL_TYPE0 0

// Mode register fields, per nibble
`define DTC_MOD_GATE 3
`define DTC_MOD_CT   2
`define DTC_MOD_HI   1
`define DTC_MOD_LO   0
`define DTC_MOD_TMR1_BASE 4
`define DTC_MOD_TMR0_BASE 0

`define DTC_RESET_BYTE 8'h00

// Timing
`define DTC_OSC_PER_MC  12
`define DTC_PRESCALE_W  5

`endif

/* dtc_pkg.sv */
// Types shared by the dual timer/counter
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT  = 2'b00,
    DTC_MODE_16BIT  = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_type;

  typedef struct packed {
    logic         gate;
    logic         ext_sel;
    dtc_mode_type mode;
  } dtc_tmode_type;

  // Register access from the processor core
  typedef struct packed {
    logic       wr;
    logic [2:0] sel;
    logic [7:0] wdata;
  } dtc_sfr_req_type;

  // Interrupt acknowledgements from the core
  typedef struct packed {
    logic t1_ovf;
    logic t0_ovf;
    logic irq1;
    logic irq0;
  } dtc_ack_type;

endpackage : dtc_pkg

/* dtc_timer.sv */
// Dual timer/counter with control and mode registers
//
// What this block does
// [R1] Timer function counts one per machine cycle
// [R2] Counter samples pin, counts high-then-low
// [R3] Count visible cycle after the detecting one
// [R4] Edge counting limited to osc/24
// [R5] Source holds each level one machine cycle
// [R6] Select bit picks machine cycle or pin
// [R7] Gate set needs irq pin high too
// [R8] Mode 0: 13-bit with 5-bit prescaler
// [R9] Mode 1: full 16-bit counter
// [R10] Mode 2: low byte reloads from high
// [R11] Timer 1 mode 3 holds its count
// [R12] Timer 0 mode 3 splits, high uses timer 1
// [R13] Overflow flags set by hardware, cleared on vector
// [R14] Run bits switch timers on and off
// [R15] Edge flags set on edge, cleared when serviced
// [R16] Type bits pick falling-edge or low-level
// [R17] Mode register nibbles: timer 1 upper
// [R18] Rollover to zero sets overflow flag
// [R19] Upper low-byte bits undefined in mode 0
// [R20] Counts readable, writable; run keeps count
// [R21] Pins synchronised before machine-cycle sampling
`include "dtc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dtc_timer #(
  parameter int OSC_PER_MC = `DTC_OSC_PER_MC
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Register port
  input  wire dtc_pkg::dtc_sfr_req_type sfr_req,
  output logic [7:0]                   sfr_rdata,
  // Interrupt acknowledgements
  input  wire dtc_pkg::dtc_ack_type     irq_ack,
  // Pins
  input  wire logic                    timer0_event_pin,
  input  wire logic                    timer1_event_pin,
  input  wire logic                    ext_irq0_pin,
  input  wire logic                    ext_irq1_pin,
  // Interrupt requests
  output logic                         ext_irq0_req,
  output logic                         ext_irq1_req,
  output logic                         timer0_irq_req,
  output logic                         timer1_irq_req
);

  if (OSC_PER_MC < 2 || OSC_PER_MC > 255) begin : g_bad_osc
    $error("OSC_PER_MC out of range");
  end

  // Synchronisers: stage one feeds stage two only
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
    end else begin
      pin_s1_ff <= {ext_irq1_pin, ext_irq0_pin, timer1_event_pin, timer0_event_pin}; // [R21]
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Machine cycle strobe, one per OSC_PER_MC oscillator clocks
  logic [7:0] div_ff;
  wire        mc_end = (div_ff == 8'(OSC_PER_MC - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= mc_end ? 8'h00 : div_ff + 8'h01; // [R1]
    end
  end
  // Sample point late in the machine cycle, count applied next cycle start
  wire sample_phase = mc_end;
  wire update_phase = (div_ff == 8'h00);

  // Registers
  logic [7:0] ctl_ff;
  logic [7:0] mod_ff;
  logic [7:0] t0_lo_ff;
  logic [7:0] t0_hi_ff;
  logic [7:0] t1_lo_ff;
  logic [7:0] t1_hi_ff;

  dtc_pkg::dtc_tmode_type m0;
  dtc_pkg::dtc_tmode_type m1;
  assign m0 = dtc_pkg::dtc_tmode_type'(mod_ff[`DTC_MOD_TMR0_BASE +: 4]); // [R17]
  assign m1 = dtc_pkg::dtc_tmode_type'(mod_ff[`DTC_MOD_TMR1_BASE +: 4]); // [R17]

  // Samples of event pins at sample phase; edge pending across cycles
  logic [1:0] ev_smp_ff;
  logic [1:0] ev_edge_ff;
  wire  [1:0] ev_now = pin_s2_ff[1:0];
  wire  [1:0] ev_fall = ev_smp_ff & ~ev_now;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_smp_ff  <= 2'b00;
      ev_edge_ff <= 2'b00;
    end else if (sample_phase) begin
      ev_smp_ff  <= ev_now;                        // [R2]
      ev_edge_ff <= ev_fall;                       // [R2] [R4]
    end else if (update_phase) begin
      ev_edge_ff <= 2'b00;                         // [R3]
    end
  end

  // Count enables, one per machine cycle at update phase
  function automatic logic tick_of(input logic run, input logic gate, input logic gpin,
                                   input logic ext_sel, input logic fall_seen);
    tick_of = run && (!gate || gpin) && (ext_sel ? fall_seen : 1'b1); // [R6] [R7] [R14]
  endfunction : tick_of

  wire t0_tick = update_phase && tick_of(ctl_ff[`DTC_CTL_RUN0], m0.gate, pin_s2_ff[2],
                                         m0.ext_sel, ev_edge_ff[0]);
  wire t1_tick = update_phase && tick_of(ctl_ff[`DTC_CTL_RUN1], m1.gate, pin_s2_ff[3],
                                         m1.ext_sel, ev_edge_ff[1]);
  // Split mode: timer 0 high byte counts machine cycles under run bit 1 only
  wire t0_split   = (m0.mode == dtc_pkg::DTC_MODE_SPLIT);
  wire th0_tick   = update_phase && t0_split && ctl_ff[`DTC_CTL_RUN1]; // [R12]
  wire t1_stopped = (m1.mode == dtc_pkg::DTC_MODE_SPLIT);              // [R11]

  // Next count for one timer; returns {overflow, high, low}
  function automatic logic [16:0] step(input dtc_pkg::dtc_mode_type md,
                                       input logic [7:0] hi, input logic [7:0] lo);
    logic [8:0] lo9;
    logic [8:0] hi9;
    lo9 = {1'b0, lo} + 9'h001;
    hi9 = {1'b0, hi} + 9'h001;
    step = {1'b0, hi, lo};
    case (md)
      dtc_pkg::DTC_MODE_13BIT: begin
        // Upper three low-byte bits keep whatever they held
        if (lo[4:0] == 5'h1f) begin
          step = {hi9[8], hi9[7:0], lo[7:5], 5'h00};          // [R8] [R19]
        end else begin
          step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};       // [R8]
        end
      end
      dtc_pkg::DTC_MODE_16BIT: begin
        if (lo9[8]) begin
          step = {hi9[8], hi9[7:0], 8'h00};                   // [R9] [R18]
        end else begin
          step = {1'b0, hi, lo9[7:0]};                        // [R9]
        end
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        step = lo9[8] ? {1'b1, hi, hi} : {1'b0, hi, lo9[7:0]}; // [R10]
      end
      dtc_pkg::DTC_MODE_SPLIT: begin
        step = {lo9[8], hi, lo9[7:0]};                        // [R12]
      end
      default: begin
        step = {1'b0, hi, lo};
      end
    endcase
  endfunction : step

  wire [16:0] t0_nxt = step(m0.mode, t0_hi_ff, t0_lo_ff);
  wire [16:0] t1_nxt = step(m1.mode, t1_hi_ff, t1_lo_ff);
  wire [8:0]  th0_inc = {1'b0, t0_hi_ff} + 9'h001;

  // Register writes
  wire wr_ctl = sfr_req.wr && (sfr_req.sel == `DTC_SEL_CONTROL);
  wire wr_mod = sfr_req.wr && (sfr_req.sel == `DTC_SEL_MODE);
  wire wr_tl0 = sfr_req.wr && (sfr_req.sel == `DTC_SEL_TMR0_LOW);
  wire wr_th0 = sfr_req.wr && (sfr_req.sel == `DTC_SEL_TMR0_HIGH);
  wire wr_tl1 = sfr_req.wr && (sfr_req.sel == `DTC_SEL_TMR1_LOW);
  wire wr_th1 = sfr_req.wr && (sfr_req.sel == `DTC_SEL_TMR1_HIGH);

  // Counter updates; a processor write wins over a count in the same cycle
  logic [7:0] nxt_t0_lo;
  logic [7:0] nxt_t0_hi;
  logic [7:0] nxt_t1_lo;
  logic [7:0] nxt_t1_hi;
  wire t0_run = t0_tick;
  wire t1_run = t1_tick && !t1_stopped;
  assign nxt_t0_lo = wr_tl0 ? sfr_req.wdata : (t0_run ? t0_nxt[7:0] : t0_lo_ff);  // [R20]
  assign nxt_t0_hi = wr_th0 ? sfr_req.wdata :
                     (t0_split ? (th0_tick ? th0_inc[7:0] : t0_hi_ff) :
                      (t0_run ? t0_nxt[15:8] : t0_hi_ff));                        // [R20]
  assign nxt_t1_lo = wr_tl1 ? sfr_req.wdata : (t1_run ? t1_nxt[7:0] : t1_lo_ff);  // [R20]
  assign nxt_t1_hi = wr_th1 ? sfr_req.wdata : (t1_run ? t1_nxt[15:8] : t1_hi_ff); // [R20]

  // Overflow events; in split mode the high byte of timer 0 owns timer 1 flag
  wire t0_ovf = t0_run && t0_nxt[16];                                   // [R18]
  wire t1_ovf = (t0_split ? (th0_tick && th0_inc[8]) : 1'b0) ||
                (!t0_split && t1_run && t1_nxt[16]);                     // [R12] [R18]

  // External interrupt edge detection, one oscillator clock resolution
  logic [1:0] irq_prev_ff;
  wire  [1:0] irq_lvl  = pin_s2_ff[3:2];
  wire  [1:0] irq_fall = irq_prev_ff & ~irq_lvl;
  wire  [1:0] irq_type = {ctl_ff[`DTC_CTL_TYPE1], ctl_ff[`DTC_CTL_TYPE0]};
  // Edge mode latches the falling edge; level mode follows the low pin
  wire  [1:0] irq_set  = (irq_type & irq_fall) | (~irq_type & ~irq_lvl); // [R16]

  // Control register next value; hardware set wins over any clear
  logic [7:0] nxt_ctl;
  always_comb begin
    nxt_ctl = wr_ctl ? sfr_req.wdata : ctl_ff;                           // [R14]
    if (irq_ack.t1_ovf) nxt_ctl[`DTC_CTL_OVF1] = 1'b0;                   // [R13]
    if (irq_ack.t0_ovf) nxt_ctl[`DTC_CTL_OVF0] = 1'b0;                   // [R13]
    if (irq_ack.irq1)   nxt_ctl[`DTC_CTL_EDGE1] = 1'b0;                  // [R15]
    if (irq_ack.irq0)   nxt_ctl[`DTC_CTL_EDGE0] = 1'b0;                  // [R15]
    if (!irq_type[1])   nxt_ctl[`DTC_CTL_EDGE1] = 1'b0;                  // [R16]
    if (!irq_type[0])   nxt_ctl[`DTC_CTL_EDGE0] = 1'b0;                  // [R16]
    if (t1_ovf)         nxt_ctl[`DTC_CTL_OVF1] = 1'b1;                   // [R13] [R18]
    if (t0_ovf)         nxt_ctl[`DTC_CTL_OVF0] = 1'b1;                   // [R13] [R18]
    if (irq_set[1])     nxt_ctl[`DTC_CTL_EDGE1] = 1'b1;                  // [R15]
    if (irq_set[0])     nxt_ctl[`DTC_CTL_EDGE0] = 1'b1;                  // [R15]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_ff      <= `DTC_RESET_BYTE;
      mod_ff      <= `DTC_RESET_BYTE;
      t0_lo_ff    <= `DTC_RESET_BYTE;
      t0_hi_ff    <= `DTC_RESET_BYTE;
      t1_lo_ff    <= `DTC_RESET_BYTE;
      t1_hi_ff    <= `DTC_RESET_BYTE;
      irq_prev_ff <= 2'b11;
    end else begin
      ctl_ff      <= nxt_ctl;
      mod_ff      <= wr_mod ? sfr_req.wdata : mod_ff;                    // [R17]
      t0_lo_ff    <= nxt_t0_lo;
      t0_hi_ff    <= nxt_t0_hi;
      t1_lo_ff    <= nxt_t1_lo;
      t1_hi_ff    <= nxt_t1_hi;
      irq_prev_ff <= irq_lvl;
    end
  end

  // Read data and interrupt request outputs, all registered
  logic [7:0] nxt_rdata;
  always_comb begin
    case (sfr_req.sel)
      `DTC_SEL_CONTROL: nxt_rdata = ctl_ff;
      `DTC_SEL_MODE:    nxt_rdata = mod_ff;
      `DTC_SEL_TMR0_LOW:  nxt_rdata = t0_lo_ff;
      `DTC_SEL_TMR0_HIGH: nxt_rdata = t0_hi_ff;
      `DTC_SEL_TMR1_LOW:  nxt_rdata = t1_lo_ff;
      `DTC_SEL_TMR1_HIGH: nxt_rdata = t1_hi_ff;
      default:          nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata      <= 8'h00;
      ext_irq0_req   <= 1'b0;
      ext_irq1_req   <= 1'b0;
      timer0_irq_req <= 1'b0;
      timer1_irq_req <= 1'b0;
    end else begin
      sfr_rdata      <= nxt_rdata;
      ext_irq0_req   <= nxt_ctl[`DTC_CTL_EDGE0];
      ext_irq1_req   <= nxt_ctl[`DTC_CTL_EDGE1];
      timer0_irq_req <= nxt_ctl[`DTC_CTL_OVF0];
      timer1_irq_req <= nxt_ctl[`DTC_CTL_OVF1];
    end
  end

endmodule : dtc_timer
`default_nettype wire

/* dtc_timer_monitor.sv */
// Port checker for the dual timer/counter, bound to every instance
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_timer_monitor #(
  parameter int OSC_PER_MC = 12
) (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst_b,
  // Register port
  input wire dtc_pkg::dtc_sfr_req_type sfr_req,
  input wire logic [7:0]               sfr_rdata,
  // Pins and requests
  input wire logic                     ext_irq0_pin,
  input wire logic                     ext_irq0_req,
  input wire logic                     ext_irq1_req,
  input wire logic                     timer0_irq_req,
  input wire logic                     timer1_irq_req
);
  // Shadows hold the last written control and mode bytes; hardware flag updates are never copied
  logic [7:0] ctl_ff, mod_ff, rd_q_ff, gap_ff;
  logic [2:0] sel_q_ff;
  logic       wr_q_ff, arm_ff, tok_q_ff;
  wire        tick_ok = ctl_ff[4] && mod_ff[3:0] == 4'h1 && !sfr_req.wr && !wr_q_ff
                        && sfr_req.sel == `DTC_SEL_TMR0_LOW && sel_q_ff == `DTC_SEL_TMR0_LOW;
  wire        chg     = sfr_rdata != rd_q_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {ctl_ff, mod_ff, rd_q_ff, gap_ff, sel_q_ff, wr_q_ff, arm_ff, tok_q_ff} <= '0;
    end else begin
      if (sfr_req.wr && sfr_req.sel == `DTC_SEL_CONTROL) ctl_ff <= sfr_req.wdata;
      if (sfr_req.wr && sfr_req.sel == `DTC_SEL_MODE) mod_ff <= sfr_req.wdata;
      rd_q_ff  <= sfr_rdata;
      sel_q_ff <= sfr_req.sel;
      wr_q_ff  <= sfr_req.wr;
      tok_q_ff <= tick_ok;
      // Arm only on a change seen after a settled read, not on a select or write
      arm_ff   <= tick_ok && (arm_ff || (chg && tok_q_ff));
      gap_ff   <= (tick_ok && !chg) ? gap_ff + 8'h01 : 8'h00;
    end
  end
  sequence s_t0_idle_read;
    (!ctl_ff[4] && !sfr_req.wr && sfr_req.sel == `DTC_SEL_TMR0_LOW) [*3];
  endsequence
  sequence s_mode_write;
    sfr_req.wr && sfr_req.sel == `DTC_SEL_MODE ##1 !sfr_req.wr && sfr_req.sel == `DTC_SEL_MODE;
  endsequence
  a_unmapped_zero: assert property (sfr_req.sel > 3'h5 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flag_mirror: assert property (sfr_req.sel == `DTC_SEL_CONTROL |=>
    {sfr_rdata[7], sfr_rdata[5], sfr_rdata[3], sfr_rdata[1]} == $past({timer1_irq_req,
    timer0_irq_req, ext_irq1_req, ext_irq0_req})) else $error("flag and request differ");
  a_tick_spacing: assert property (tick_ok && arm_ff |->
    (chg ? gap_ff == OSC_PER_MC - 1 : gap_ff < OSC_PER_MC - 1)) else $error("tick spacing");
  a_run_off_hold: assert property (s_t0_idle_read |-> $stable(sfr_rdata))
    else $error("stopped timer moved");
  a_t1_split_hold: assert property ((mod_ff[5:4] == 2'b11 && !sfr_req.wr
    && sfr_req.sel == `DTC_SEL_TMR1_LOW) [*3] |-> $stable(sfr_rdata)) else $error("t1 moved");
  a_mode_readback: assert property (s_mode_write |=> sfr_rdata == $past(sfr_req.wdata, 2))
    else $error("mode readback wrong");
  a_edge_sets_flag: assert property (ctl_ff[0] && $fell(ext_irq0_pin)
    |-> ##[1:4] ext_irq0_req) else $error("edge not flagged");
  a_level_follows: assert property ((!ctl_ff[0] && !ext_irq0_pin) [*5] |-> ext_irq0_req)
    else $error("low level not flagged");
endmodule : dtc_timer_monitor
bind dtc_timer dtc_timer_monitor #(.OSC_PER_MC(OSC_PER_MC)) mon_u (.clk(clk), .rst_b(rst_b),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .ext_irq0_pin(ext_irq0_pin),
  .ext_irq0_req(ext_irq0_req), .ext_irq1_req(ext_irq1_req), .timer0_irq_req(timer0_irq_req),
  .timer1_irq_req(timer1_irq_req));
`default_nettype wire

/* dtc_core_model.sv */
// Processor core stand-in that vectors to pending interrupts
`timescale 1ns/1ps
`default_nettype none
module dtc_core_model (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_b,
  // Vectoring enable and pending requests
  input  wire logic           ack_en,
  input  wire logic [3:0]     req,
  // Acknowledge pulses
  output dtc_pkg::dtc_ack_type irq_ack
);
  // One pulse per vector; a gap cycle lets the flag fall before looking again
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) irq_ack <= '0;
    else irq_ack <= (ack_en && irq_ack == '0) ? req : 4'h0;
  end
endmodule : dtc_core_model
`default_nettype wire

/* dtc_timer_tb_top.sv */
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_timer_tb_top;
  localparam int MC = 4;
  logic                     clk, rst_b, ack_en, p0, i0, i1;
  logic [7:0]               rdata, v;
  wire  [3:0]               reqs;
  dtc_pkg::dtc_sfr_req_type req;
  dtc_pkg::dtc_ack_type     ack;
  int                       err_count, tests_run;
  dtc_timer #(.OSC_PER_MC(MC)) dut_u (.clk(clk), .rst_b(rst_b), .sfr_req(req),
    .sfr_rdata(rdata), .irq_ack(ack), .timer0_event_pin(p0), .timer1_event_pin(1'b0),
    .ext_irq0_pin(i0), .ext_irq1_pin(i1), .ext_irq0_req(reqs[0]), .ext_irq1_req(reqs[1]),
    .timer0_irq_req(reqs[2]), .timer1_irq_req(reqs[3]));
  dtc_core_model core_u (.clk(clk), .rst_b(rst_b), .ack_en(ack_en), .req(reqs), .irq_ack(ack));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, s, d};
    @(posedge clk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] s);
    @(posedge clk) req.sel <= s;
    repeat (2) @(posedge clk);
    @(negedge clk) v = rdata;
  endtask : rd
  task automatic wait_req(input int k, input logic lvl);
    int n;
    @(negedge clk);
    for (n = 0; n < 3000 && reqs[k] !== lvl; n++) @(negedge clk);
    if (n == 3000) begin
      err_count++;
      stop_test();
    end
  endtask : wait_req
  task automatic t_regs;
    wr(3'h6, 8'hff);
    rd(3'h6);
    chk(v, 8'h00, "unmapped");
    wr(`DTC_SEL_MODE, 8'ha5);
    rd(`DTC_SEL_MODE);
    chk(v, 8'ha5, "mode");
  endtask : t_regs
  // Run to overflow, stop within one machine cycle, then let the core vector
  task automatic ovf(input logic [7:0] m, h, l, c, input int k, input logic [7:0] el, eh);
    wr(`DTC_SEL_MODE, m);
    wr(`DTC_SEL_TMR0_HIGH, h);
    wr(`DTC_SEL_CONTROL, c);
    wr(`DTC_SEL_TMR0_LOW, l);
    wait_req(k, 1'b1);
    wr(`DTC_SEL_CONTROL, k == 3 ? 8'h80 : 8'h20);
    rd(`DTC_SEL_TMR0_LOW);
    chk(v & (m[1:0] == 2'b00 ? 8'h1f : 8'hff), el, "low byte");
    rd(`DTC_SEL_TMR0_HIGH);
    chk(v, eh, "high byte");
    @(posedge clk) ack_en <= 1'b1;
    wait_req(k, 1'b0);
    @(posedge clk) ack_en <= 1'b0;
  endtask : ovf
  task automatic t_count;
    wr(`DTC_SEL_MODE, 8'h05);
    wr(`DTC_SEL_TMR0_LOW, 8'h00);
    wr(`DTC_SEL_CONTROL, 8'h10);
    repeat (6) begin
      @(posedge clk) p0 <= !p0;
      repeat (2 * MC) @(posedge clk);
    end
    wr(`DTC_SEL_CONTROL, 8'h00);
    rd(`DTC_SEL_TMR0_LOW);
    chk(v, 8'h03, "pin falls");
  endtask : t_count
  task automatic t_gate;
    @(posedge clk) i0 <= 1'b0;
    wr(`DTC_SEL_MODE, 8'h09);
    wr(`DTC_SEL_TMR0_LOW, 8'h00);
    wr(`DTC_SEL_CONTROL, 8'h10);
    repeat (4 * MC) @(posedge clk);
    rd(`DTC_SEL_TMR0_LOW);
    chk(v, 8'h00, "gated");
    @(posedge clk) i0 <= 1'b1;
    repeat (4 * MC) @(posedge clk);
    rd(`DTC_SEL_TMR0_LOW);
    chk({7'h0, v != 8'h00}, 8'h01, "ungated");
    wr(`DTC_SEL_CONTROL, 8'h00);
  endtask : t_gate
  task automatic t_irq;
    wr(`DTC_SEL_CONTROL, 8'h01);
    @(posedge clk) i0 <= 1'b0;
    wait_req(0, 1'b1);
    @(posedge clk) ack_en <= 1'b1;
    wait_req(0, 1'b0);
    @(posedge clk) ack_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk({7'h0, reqs[0]}, 8'h00, "edge flag");
    wr(`DTC_SEL_CONTROL, 8'h00);
    wait_req(0, 1'b1);
    @(posedge clk) i0 <= 1'b1;
    wait_req(0, 1'b0);
    wr(`DTC_SEL_CONTROL, 8'h04);
    @(posedge clk) i1 <= 1'b0;
    wait_req(1, 1'b1);
    @(posedge clk) ack_en <= 1'b1;
    wait_req(1, 1'b0);
    @(posedge clk) ack_en <= 1'b0;
  endtask : t_irq
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  initial begin
    {rst_b, ack_en, p0, i0, req, err_count, tests_run} = '0;
    i0 = 1'b1;
    i1 = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    ovf(8'h01, 8'hff, 8'hff, 8'h10, 2, 8'h00, 8'h00);
    ovf(8'h00, 8'hff, 8'h1f, 8'h10, 2, 8'h00, 8'h00);
    ovf(8'h02, 8'hf0, 8'hfe, 8'h10, 2, 8'hf0, 8'hf0);
    ovf(8'h33, 8'hff, 8'h55, 8'h40, 3, 8'h55, 8'h00);
    rd(`DTC_SEL_TMR1_LOW);
    chk(v, 8'h00, "held count");
    t_count();
    t_gate();
    t_irq();
    stop_test();
  end
endmodule : dtc_timer_tb_top
`default_nettype wire
